// ===== design/rscp_pkg.sv
// Constants, field layout and timing for the receiver serial config port
package rscp_pkg;
  localparam int              CFG_W        = 20;
  localparam int              CNT_W        = 5;
  localparam int              TMR_W        = 26;
  localparam logic [CFG_W-1:0] CFG_RESET   = 20'h00000;
  localparam int              DES_LSB      = 0;
  localparam int              DES_W        = 3;
  localparam int              BW_LSB       = 3;
  localparam int              BW_W         = 2;
  localparam int              SLC_LSB      = 5;
  localparam int              SLC_W        = 2;
  localparam int              BCK_LSB      = 7;
  localparam int              BCK_W        = 2;
  localparam int              WIN_LSB      = 9;
  localparam int              WIN_W        = 3;
  localparam int              SLP_LSB      = 12;
  localparam int              SLP_W        = 3;
  localparam int              AUTOPOLL_BIT = 15;
  localparam int              UNUSED_BIT   = 16;
  localparam int              SQ_BIT       = 17;
  localparam int              WDOG_BIT     = 18;
  localparam int              SIGNAL_STRENGTH_OUTPUT_BIT     = 19;
  localparam int              SQ_NBITS     = 18;
  localparam int              CLK_NS       = 8;
  localparam int              T_MIN_NS     = 100;
  localparam int              T_OE_MAX_NS  = 100;
  localparam int              PHASE_CYC    = (T_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int              OE_MAX_CYC   = T_OE_MAX_NS / CLK_NS;
  localparam int              PH_W         = $clog2(PHASE_CYC + 1);
  localparam int              PEND_NS      = 1000;
  localparam int              PEND_CYC     = (PEND_NS + CLK_NS - 1) / CLK_NS;
  localparam int              WIN_UNIT_NS  = 108250;
  localparam int              SLEEP_UNIT_MS = 40;
  localparam int              STARTUP_US   = 1000;
  localparam int              WDOG_MS      = 10;
  localparam int              NS_PER_US    = 1000;
  localparam int              NS_PER_MS    = 1000000;

  // Bits needed by the bit-check: twice the code
  function automatic logic [BCK_W:0] bits_needed(input logic [BCK_W-1:0] c);
    bits_needed = {c, 1'b0};
  endfunction

  // Mask of the low n bits, full word from CFG_W upward
  function automatic logic [CFG_W-1:0] low_mask(input logic [CNT_W-1:0] n);
    logic [CFG_W:0] one_hot;
    one_hot  = (CFG_W+1)'(1) << n;
    low_mask = (n >= CNT_W'(CFG_W)) ? '1 : CFG_W'(one_hot - (CFG_W+1)'(1));
  endfunction
endpackage

// ===== design/rscp_if.sv
// Two-pin serial link plus parallel control pins between controller and radio
`timescale 1ns/1ns
`default_nettype none
interface rscp_if;
  logic sclk;
  logic host_do;
  logic host_oe;
  logic dev_do;
  logic dev_oe;
  logic line;
  logic squelch_input_pin;
  logic power_down_pin;
  logic bandwidth_select_lo_pin;
  logic bandwidth_select_hi_pin;

  // Undriven data line settles low
  assign line = dev_oe ? dev_do : (host_oe ? host_do : 1'b0);

  modport dev (
    input  sclk,
    input  line,
    input  squelch_input_pin,
    input  power_down_pin,
    output dev_do,
    output dev_oe
  );
  modport host (
    output sclk,
    output host_do,
    output host_oe,
    output squelch_input_pin,
    output power_down_pin,
    output bandwidth_select_lo_pin,
    output bandwidth_select_hi_pin
  );
endinterface
`default_nettype wire

// ===== design/rscp_host.sv
// Controller end: drives start, bits and stop sequences onto the link
`timescale 1ns/1ns
`default_nettype none
module rscp_host (
  rscp_if.host                        LINK,
  input  wire logic                   CLK,
  input  wire logic                   RESET_N,
  input  wire logic                   CMD_VALID,
  input  wire logic [rscp_pkg::CFG_W-1:0] CMD_WORD,
  input  wire logic [rscp_pkg::CNT_W-1:0] CMD_NBITS,
  input  wire logic                   POWER_DOWN,
  output logic                        CMD_READY,
  output logic                        CMD_DONE
);
  import rscp_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE, H_OPEN, H_DRV0, H_CLKLO, H_CLKHI, H_DHI, H_DLO,
    H_BLO, H_BSET, H_BHI, H_S0, H_S1, H_S2, H_CLOSE
  } rscp_hstate_t;

  rscp_hstate_t           hst_q;
  rscp_hstate_t           hst_d;
  logic [PH_W-1:0]        ph_q;
  logic [CFG_W-1:0]       word_q;
  logic [CNT_W-1:0]       left_q;
  logic                   sclk_q;
  logic                   do_q;
  logic                   oe_q;
  logic                   ready_q;
  logic                   done_q;
  logic                   pdn_q;
  logic                   pins_hi_q;

  wire                    take     = (hst_q == H_IDLE) && CMD_VALID && ready_q;
  wire                    ph_end   = (ph_q == PH_W'(PHASE_CYC - 1));
  // Zero or oversize counts send the whole word
  wire                    n_full   = (CMD_NBITS == '0) ||
                                     (CMD_NBITS > CNT_W'(CFG_W));
  wire [CNT_W-1:0]        n_eff    = n_full ? CNT_W'(CFG_W) : CMD_NBITS;
  wire [CFG_W-1:0]        word_clr = CMD_WORD & ~(CFG_W'(1) << UNUSED_BIT);
  wire                    sclk_d   = !(hst_d inside {H_IDLE, H_CLKLO, H_BLO,
                                                     H_BSET, H_CLOSE});
  wire                    oe_d     = !(hst_d inside {H_IDLE, H_OPEN,
                                                     H_CLOSE});
  wire                    do_d     = (hst_d == H_BSET) ? word_q[CFG_W-1] :
                                     (hst_d inside {H_DHI, H_S1}) ? 1'b1 :
                                     (hst_d inside {H_BLO, H_BHI}) ? do_q :
                                     1'b0;

  always_comb begin
    hst_d = hst_q;
    unique case (hst_q)
      H_IDLE:  if (take) hst_d = H_OPEN;
      H_OPEN:  if (ph_end) hst_d = H_DRV0;
      H_DRV0:  if (ph_end) hst_d = H_CLKLO;
      H_CLKLO: if (ph_end) hst_d = H_CLKHI;
      H_CLKHI: if (ph_end) hst_d = H_DHI;
      H_DHI:   if (ph_end) hst_d = H_DLO;
      H_DLO:   if (ph_end) hst_d = H_BLO;
      H_BLO:   if (ph_end) hst_d = H_BSET;
      H_BSET:  if (ph_end) hst_d = H_BHI;
      H_BHI:   if (ph_end) hst_d = (left_q == CNT_W'(1)) ? H_S0 : H_BLO;
      H_S0:    if (ph_end) hst_d = H_S1;
      H_S1:    if (ph_end) hst_d = H_S2;
      H_S2:    if (ph_end) hst_d = H_CLOSE;
      H_CLOSE: if (ph_end) hst_d = H_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      hst_q <= H_IDLE;
      ph_q  <= '0;
    end else begin
      hst_q <= hst_d;
      // Every level holds a full phase, so each interval exceeds 0.1 us
      ph_q  <= (hst_d != hst_q) ? '0 : ph_q + PH_W'(1);
    end
  end

  // Word is aligned so its top bit is always the next to send
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      word_q <= '0;
      left_q <= '0;
    end else if (take) begin
      word_q <= word_clr << (CNT_W'(CFG_W) - n_eff);
      left_q <= n_eff;
    end else if (hst_q == H_BHI && ph_end) begin
      word_q <= word_q << 1;
      left_q <= left_q - CNT_W'(1);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sclk_q    <= 1'b0;
      do_q      <= 1'b0;
      oe_q      <= 1'b0;
      ready_q   <= 1'b0;
      done_q    <= 1'b0;
      pdn_q     <= 1'b0;
      pins_hi_q <= 1'b0;
    end else begin
      sclk_q    <= sclk_d;
      do_q      <= do_d;
      oe_q      <= oe_d;
      ready_q   <= (hst_d == H_IDLE) && !take;
      done_q    <= (hst_q == H_CLOSE) && ph_end;
      pdn_q     <= POWER_DOWN;
      pins_hi_q <= 1'b1;
    end
  end

  assign LINK.sclk                    = sclk_q;
  assign LINK.host_do                 = do_q;
  assign LINK.host_oe                 = oe_q;
  assign LINK.power_down_pin          = pdn_q;
  assign LINK.squelch_input_pin       = pins_hi_q;
  assign LINK.bandwidth_select_lo_pin = pins_hi_q;
  assign LINK.bandwidth_select_hi_pin = pins_hi_q;
  assign CMD_READY                    = ready_q;
  assign CMD_DONE                     = done_q;
endmodule
`default_nettype wire

// ===== design/rscp_device.sv
// Receiver end: serial config capture, pin turnaround and receiver sequencing
`timescale 1ns/1ns
`default_nettype none
module rscp_device #(
  parameter int WIN_UNIT_CYC   = (rscp_pkg::WIN_UNIT_NS + rscp_pkg::CLK_NS - 1)
                                 / rscp_pkg::CLK_NS,
  parameter int SLEEP_UNIT_CYC = rscp_pkg::SLEEP_UNIT_MS
                                 * (rscp_pkg::NS_PER_MS / rscp_pkg::CLK_NS),
  parameter int STARTUP_CYC    = rscp_pkg::STARTUP_US
                                 * rscp_pkg::NS_PER_US / rscp_pkg::CLK_NS,
  parameter int WDOG_CYC       = rscp_pkg::WDOG_MS
                                 * (rscp_pkg::NS_PER_MS / rscp_pkg::CLK_NS)
) (
  rscp_if.dev                             LINK,
  input  wire logic                       CLK,
  input  wire logic                       RESET_N,
  input  wire logic                       RX_DATA,
  output logic [rscp_pkg::CFG_W-1:0]      CFG_WORD,
  output logic [rscp_pkg::DES_W-1:0]      DESENSE,
  output logic [rscp_pkg::BW_W-1:0]       DEMOD_BW,
  output logic [rscp_pkg::SLC_W-1:0]      SLICE_LEVEL,
  output logic                            WATCHDOG_OFF,
  output logic                            SIGNAL_STRENGTH_OUTPUT_OFFSET,
  output logic                            RX_AWAKE
);
  import rscp_pkg::*;

  typedef enum logic [1:0] {P_IDLE, P_PEND, P_PROG, P_STOP} rscp_pstate_t;
  typedef enum logic [2:0] {R_OFF, R_WARM, R_SLEEP, R_CHECK, R_RUN}
    rscp_rstate_t;

  localparam int SYN_W = 5;
  localparam int S_CLK = 0;
  localparam int S_LN  = 1;
  localparam int S_SQ  = 2;
  localparam int S_PD  = 3;
  localparam int S_RX  = 4;

  logic [CFG_W-1:0]      shift_s;
  logic [SYN_W-1:0]      m1_q;
  logic [SYN_W-1:0]      m2_q;
  logic [SYN_W-1:0]      m3_q;
  rscp_pstate_t          pst_q;
  rscp_pstate_t          pst_d;
  rscp_rstate_t          rst_q;
  rscp_rstate_t          rst_d;
  logic [CNT_W-1:0]      nbit_q;
  logic [TMR_W-1:0]      pend_q;
  logic [TMR_W-1:0]      tmr_q;
  logic [TMR_W-1:0]      ivl_q;
  logic [BCK_W:0]        ok_q;
  logic [CFG_W-1:0]      cfg_q;
  logic                  oe_q;
  logic                  do_q;
  logic                  awake_q;

  // Link clock domain: only the shift register lives here
  always_ff @(posedge LINK.sclk) begin
    shift_s <= {shift_s[CFG_W-2:0], LINK.line};
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      m1_q <= '0;
      m2_q <= '0;
      m3_q <= '0;
    end else begin
      m1_q <= {RX_DATA, LINK.power_down_pin, LINK.squelch_input_pin,
               LINK.line, LINK.sclk};
      m2_q <= m1_q;
      m3_q <= m2_q;
    end
  end

  wire sclk_w    = m2_q[S_CLK];
  wire sclk_rise = m2_q[S_CLK] && !m3_q[S_CLK];
  // Host moves data only while the clock is low, so a rise seen
  // with the clock high can only be a start or stop pulse
  wire line_rise = m2_q[S_LN] && !m3_q[S_LN] && sclk_w;
  wire pdn_w     = m2_q[S_PD];
  wire rx_w      = m2_q[S_RX];
  wire rx_edge   = m2_q[S_RX] ^ m3_q[S_RX];
  wire apply     = (pst_q == P_STOP) && !sclk_w;
  wire [CFG_W-1:0] mask = low_mask(nbit_q);
  wire bit_tick  = (pst_q == P_PROG) && sclk_rise && (nbit_q != '1);
  wire [CFG_W-1:0] cfg_nxt = (cfg_q & ~mask) | (shift_s & mask);

  always_comb begin
    pst_d = pst_q;
    unique case (pst_q)
      P_IDLE: if (sclk_w) pst_d = P_PEND;
      P_PEND: begin
        if (line_rise) pst_d = P_PROG;
        else if (pend_q >= TMR_W'(PEND_CYC)) pst_d = P_IDLE;
      end
      P_PROG: if (line_rise) pst_d = P_STOP;
      P_STOP: if (!sclk_w) pst_d = P_IDLE;
    endcase
  end

  // Lone clock pulse without a start times out back to idle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pst_q  <= P_IDLE;
      pend_q <= '0;
    end else begin
      pst_q  <= pst_d;
      pend_q <= (sclk_w || pst_q != P_PEND) ? '0 : pend_q + TMR_W'(1);
    end
  end

  // A new frame starts its count from zero
  always_ff @(posedge CLK) begin
    if (!RESET_N)
      nbit_q <= '0;
    else if (pst_q == P_PEND)
      nbit_q <= '0;
    else if (bit_tick)
      nbit_q <= nbit_q + CNT_W'(1);
  end

  // Shift word is static here: clock stayed high through the stop
  always_ff @(posedge CLK) begin
    if (!RESET_N)
      cfg_q <= CFG_RESET;
    else if (apply)
      cfg_q <= cfg_nxt;
  end

  // Three-cycle path from pin to release, well inside 0.1 us
  always_ff @(posedge CLK) begin
    if (!RESET_N)
      oe_q <= 1'b0;
    else
      oe_q <= (pst_d == P_IDLE) && !sclk_w;
  end

  wire [BCK_W:0]   need      = bits_needed(cfg_q[BCK_LSB +: BCK_W]);
  wire [TMR_W-1:0] win_lim   = TMR_W'((int'(cfg_q[WIN_LSB +: WIN_W]) + 1)
                                      * WIN_UNIT_CYC);
  wire [TMR_W-1:0] sleep_lim = TMR_W'(int'(cfg_q[SLP_LSB +: SLP_W])
                                      * SLEEP_UNIT_CYC);
  wire             autopoll  = cfg_q[AUTOPOLL_BIT];
  wire             sq_on     = !m2_q[S_SQ] || cfg_q[SQ_BIT];
  wire             wdog_hit  = autopoll && !cfg_q[WDOG_BIT] &&
                               ivl_q >= TMR_W'(WDOG_CYC);
  wire             good_ivl  = ivl_q >= win_lim;
  // Zero needed bits lets the first check pass at once
  wire             pass      = (need == '0) ||
                               (rx_edge && good_ivl && ok_q + 1'b1 >= need);

  // Power-down overrides every state, so it is tested last
  always_comb begin
    rst_d = rst_q;
    unique case (rst_q)
      R_OFF:   rst_d = R_WARM;
      R_WARM:  if (tmr_q >= TMR_W'(STARTUP_CYC))
                 rst_d = (sq_on || autopoll) ? R_CHECK : R_RUN;
      R_SLEEP: if (tmr_q >= sleep_lim) rst_d = R_CHECK;
      R_CHECK: begin
        if (pass) rst_d = R_RUN;
        else if (autopoll && ((rx_edge && !good_ivl) || wdog_hit))
          rst_d = R_SLEEP;
      end
      R_RUN:   if (wdog_hit) rst_d = R_SLEEP;
      default: rst_d = R_OFF;
    endcase
    if (pdn_w) rst_d = R_OFF;
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rst_q <= R_OFF;
      tmr_q <= '0;
      ivl_q <= '0;
    end else begin
      rst_q <= rst_d;
      tmr_q <= (rst_d != rst_q) ? '0 : tmr_q + TMR_W'(1);
      ivl_q <= (rx_edge || rst_d != rst_q) ? '0 :
               (ivl_q == '1) ? ivl_q : ivl_q + TMR_W'(1);
    end
  end

  // A short interval breaks the run of good windows
  always_ff @(posedge CLK) begin
    if (!RESET_N || rst_q != R_CHECK || (rx_edge && !good_ivl))
      ok_q <= '0;
    else if (rx_edge && ok_q != '1)
      ok_q <= ok_q + 1'b1;
  end

  // Data only leaves in RUN: squelch and power-down hold it low
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      do_q    <= 1'b0;
      awake_q <= 1'b0;
    end else begin
      do_q    <= (rst_q == R_RUN) && rx_w;
      awake_q <= rst_d inside {R_CHECK, R_RUN};
    end
  end

  assign LINK.dev_do  = do_q;
  assign LINK.dev_oe  = oe_q;
  assign CFG_WORD     = cfg_q;
  assign DESENSE      = cfg_q[DES_LSB +: DES_W];
  assign DEMOD_BW     = cfg_q[BW_LSB +: BW_W];
  assign SLICE_LEVEL  = cfg_q[SLC_LSB +: SLC_W];
  assign WATCHDOG_OFF = cfg_q[WDOG_BIT];
  assign SIGNAL_STRENGTH_OUTPUT_OFFSET  = cfg_q[SIGNAL_STRENGTH_OUTPUT_BIT];
  assign RX_AWAKE     = awake_q;
endmodule
`default_nettype wire

// ===== testbench/rscp_asserts.sv
// Link protocol assertions for the serial config port
`timescale 1ns/1ns
`default_nettype none
module rscp_asserts (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic sclk,
  input wire logic host_do,
  input wire logic host_oe,
  input wire logic dev_do,
  input wire logic dev_oe,
  input wire logic squelch_input_pin,
  input wire logic power_down_pin,
  input wire logic bandwidth_select_lo_pin,
  input wire logic bandwidth_select_hi_pin
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_no_contend:
    assert property (!(dev_oe && host_oe)) else $error("both ends drive");
  a_hold_release:
    assert property (sclk [*4] |-> !dev_oe) else $error("device drives");
  a_oe_release:
    assert property ($rose(sclk) && dev_oe |-> ##[1:3] !dev_oe)
      else $error("late turnaround");
  a_sclk_high_time:
    assert property ($rose(sclk) |-> sclk [*8] ##1 sclk [*5])
      else $error("short clock high");
  a_sclk_low_time:
    assert property ($fell(sclk) |-> !sclk [*8] ##1 !sclk [*5])
      else $error("short clock low");
  a_start_open:
    assert property ($rose(host_oe) |-> sclk && !host_do)
      else $error("bad start drive");
  a_stop_close:
    assert property ($fell(host_oe) |-> $fell(sclk))
      else $error("bad stop release");
  a_output_return:
    assert property ($fell(sclk) && !host_oe |-> ##[1:8] dev_oe)
      else $error("output not restored");
  a_pins_high:
    assert property ($past(RESET_N) |-> bandwidth_select_lo_pin
                     && bandwidth_select_hi_pin && squelch_input_pin)
      else $error("parallel pin low");
  a_off_quiet:
    assert property (power_down_pin [*8] |-> !dev_do)
      else $error("data while off");
endmodule
`default_nettype wire

// ===== testbench/rscp_tb.sv
// Bench joining controller and receiver ends across the serial link
`timescale 1ns/1ns
`default_nettype none
module rscp_tb;
  import rscp_pkg::*;
  typedef struct packed {
    logic [CFG_W-1:0] word;
    logic [CNT_W-1:0] n;
  } rscp_exp_t;
  logic             clk;
  logic             reset_n;
  logic             cmd_valid;
  logic [CFG_W-1:0] cmd_word;
  logic [CNT_W-1:0] cmd_nbits;
  logic             power_down;
  logic             rx_data;
  logic             cmd_ready;
  logic             cmd_done;
  logic [CFG_W-1:0] cfg_word;
  logic [DES_W-1:0] desense;
  logic [BW_W-1:0]  demod_bw;
  logic [SLC_W-1:0] slice_level;
  logic             watchdog_off;
  logic             signal_strength_output_offset;
  logic             rx_awake;
  logic [CFG_W-1:0] model;
  logic [CFG_W-1:0] e;
  logic [15:0]      lfsr_q;
  logic [31:0]      sh;
  logic             sclk_d;
  logic             oe_d;
  rscp_exp_t        x;
  rscp_exp_t        wire_q[$];
  logic [CFG_W-1:0] cfg_q[$];
  int               fail_count;
  int               cmp_count;
  int               cnt;

  rscp_if rscp_if_i ();
  rscp_host rscp_host_i (.LINK(rscp_if_i), .CLK(clk), .RESET_N(reset_n),
    .CMD_VALID(cmd_valid), .CMD_WORD(cmd_word), .CMD_NBITS(cmd_nbits),
    .POWER_DOWN(power_down), .CMD_READY(cmd_ready), .CMD_DONE(cmd_done));
  // Short counts keep the run brief
  rscp_device #(.WIN_UNIT_CYC(8), .SLEEP_UNIT_CYC(50), .STARTUP_CYC(20),
    .WDOG_CYC(200)) rscp_device_i (.LINK(rscp_if_i), .CLK(clk),
    .RESET_N(reset_n), .RX_DATA(rx_data), .CFG_WORD(cfg_word),
    .DESENSE(desense), .DEMOD_BW(demod_bw), .SLICE_LEVEL(slice_level),
    .WATCHDOG_OFF(watchdog_off), .SIGNAL_STRENGTH_OUTPUT_OFFSET(signal_strength_output_offset),
    .RX_AWAKE(rx_awake));
  rscp_asserts rscp_asserts_i (.CLK(clk), .RESET_N(reset_n),
    .sclk(rscp_if_i.sclk), .host_do(rscp_if_i.host_do),
    .host_oe(rscp_if_i.host_oe), .dev_do(rscp_if_i.dev_do),
    .dev_oe(rscp_if_i.dev_oe),
    .squelch_input_pin(rscp_if_i.squelch_input_pin),
    .power_down_pin(rscp_if_i.power_down_pin),
    .bandwidth_select_lo_pin(rscp_if_i.bandwidth_select_lo_pin),
    .bandwidth_select_hi_pin(rscp_if_i.bandwidth_select_hi_pin));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [CFG_W-1:0] keep_mask(input int n);
    keep_mask = (n >= CFG_W) ? '1 : CFG_W'((1 << n) - 1);
  endfunction

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [CFG_W-1:0] w, input int n);
    logic [CFG_W-1:0] m;
    int               k;
    m = keep_mask(n);
    @(negedge clk);
    cmd_word = w;
    cmd_nbits = CNT_W'(n);
    cmd_valid = 1'b1;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) begin
      check("cmd ready", 32'(cmd_ready), 32'h1);
      end_sim();
    end
    w[UNUSED_BIT] = 1'b0;
    model = (model & ~m) | (w & m);
    cfg_q.push_back(model);
    wire_q.push_back('{w & m, CNT_W'(n)});
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  always @(negedge clk) begin
    if (reset_n && cmd_done === 1'b1) begin
      if (cfg_q.size() == 0) begin
        check("cfg queue", 32'(cfg_q.size()), 32'h1);
      end else begin
        e = cfg_q.pop_front();
        check("cfg_word", 32'(cfg_word), 32'(e));
        check("desense", 32'(desense), 32'(e[2:0]));
        check("demod_bw", 32'(demod_bw), 32'(e[4:3]));
        check("slice", 32'(slice_level), 32'(e[6:5]));
        check("watchdog", 32'(watchdog_off), 32'(e[18]));
        check("signal_strength_output", 32'(signal_strength_output_offset), 32'(e[19]));
      end
    end
  end

  // Wire order seen at each clock rise while the controller drives
  always @(negedge clk) begin
    if (rscp_if_i.host_oe && rscp_if_i.sclk && !sclk_d) begin
      sh = {sh[30:0], rscp_if_i.line};
      cnt++;
    end
    if (oe_d && !rscp_if_i.host_oe && wire_q.size() > 0) begin
      x = wire_q.pop_front();
      check("bit count", 32'(cnt), 32'(x.n) + 1);
      check("wire bits", sh & 32'(keep_mask(x.n)), 32'(x.word));
      cnt = 0;
    end
    sclk_d = rscp_if_i.sclk;
    oe_d = rscp_if_i.host_oe;
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    check("run time", 32'h1, 32'h0);
    end_sim();
  end

  initial begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = '0;
    cmd_nbits = '0;
    power_down = 1'b0;
    rx_data = 1'b0;
    lfsr_q = 16'h002D;
    model = CFG_RESET;
    sh = '0;
    cnt = 0;
    sclk_d = 1'b0;
    oe_d = 1'b0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    send(20'h4C760, 20);
    send(20'h00005, 3);
    send(20'h2C765, 18);
    $display("test fixed writes done");
    for (int i = 0; i < 6; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      cmd_word = {lfsr_q[3:0], lfsr_q};
      lfsr_q = lfsr_next(lfsr_q);
      send(cmd_word, 1 + int'(lfsr_q) % CFG_W);
    end
    send(20'h00060, 20);
    for (int k = 0; k < 2000 && cfg_q.size() > 0; k++) begin
      @(negedge clk);
    end
    check("pending", 32'(cfg_q.size()), 32'h0);
    $display("test random writes done");
    power_down = 1'b1;
    repeat (30) @(negedge clk);
    check("awake off", 32'(rx_awake), 32'h0);
    power_down = 1'b0;
    repeat (40) @(negedge clk);
    check("awake on", 32'(rx_awake), 32'h1);
    rx_data = 1'b1;
    repeat (8) @(negedge clk);
    check("data high", 32'(rscp_if_i.line), 32'h1);
    rx_data = 1'b0;
    repeat (8) @(negedge clk);
    check("data low", 32'(rscp_if_i.line), 32'h0);
    $display("test power cycle done");
    // Squelch by D17 with a two-bit check before data may pass
    send(20'h200E0, 20);
    for (int k = 0; k < 2000 && cfg_q.size() > 0; k++) begin
      @(negedge clk);
    end
    check("pending sq", 32'(cfg_q.size()), 32'h0);
    power_down = 1'b1;
    repeat (30) @(negedge clk);
    power_down = 1'b0;
    repeat (40) @(negedge clk);
    check("check awake", 32'(rx_awake), 32'h1);
    rx_data = 1'b1;
    repeat (12) @(negedge clk);
    check("squelched", 32'(rscp_if_i.line), 32'h0);
    rx_data = 1'b0;
    repeat (12) @(negedge clk);
    rx_data = 1'b1;
    repeat (8) @(negedge clk);
    check("passed", 32'(rscp_if_i.line), 32'h1);
    $display("test squelch done");
    end_sim();
  end
endmodule
`default_nettype wire
